/* verilog/async_timer_pkg.sv */
package async_timer_pkg;

	// bus shape between processor and timer
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam int NREG   = 3;

	// register addresses on the timer link
	localparam logic [ADDR_W-1:0] ADDR_COUNTER = 3'h0;
	localparam logic [ADDR_W-1:0] ADDR_COMPARE = 3'h1;
	localparam logic [ADDR_W-1:0] ADDR_CONTROL = 3'h2;
	localparam logic [ADDR_W-1:0] ADDR_STATUS  = 3'h3;
	localparam logic [ADDR_W-1:0] ADDR_SFR     = 3'h4;
	localparam logic [ADDR_W-1:0] ADDR_MASK    = 3'h5;
	localparam logic [ADDR_W-1:0] ADDR_FLAGS   = 3'h6;

	// holding register slots, equal to busy bit positions in the status register
	localparam logic [1:0] SLOT_CTRL = 2'h0;
	localparam logic [1:0] SLOT_CMP  = 2'h1;
	localparam logic [1:0] SLOT_CNT  = 2'h2;
	localparam logic [1:0] SLOT_NONE = 2'h3;

	// field positions
	localparam int ASYNC_SEL_BIT   = 3;
	localparam int PSR_BIT         = 0;
	localparam int CS_LSB          = 0;
	localparam int CS_MSB          = 2;
	localparam int CTRL_TOGGLE_BIT = 4;
	localparam int FLAG_OVF        = 0;
	localparam int FLAG_CMP        = 1;
	localparam int NFLAG           = 2;

	// reset values
	localparam logic [DATA_W-1:0] BYTE_RESET = 8'h00;
	localparam logic [DATA_W-1:0] BYTE_ONE   = 8'h01;
	localparam logic [DATA_W-1:0] BYTE_MAX   = 8'hFF;

	// timing
	localparam int         XFER_EDGES      = 2;
	localparam logic [1:0] XFER_LAST       = 2'(XFER_EDGES - 1);
	localparam int         IRQ_SYNC_CYCLES = 3;
	localparam int         CLK_MHZ         = 250;
	localparam int         OSC_SETTLE_MS   = 1000;
	localparam int         OSC_SETTLE_CYCLES = OSC_SETTLE_MS * CLK_MHZ * 1000;

	// prescaler
	localparam int DIV_W = 10;

	typedef enum logic [2:0] {
		SLP_AWAKE,
		SLP_IDLE,
		SLP_POWER_SAVE,
		SLP_POWER_DOWN,
		SLP_STANDBY,
		SLP_EXT_STANDBY
	} sleep_mode_t;

	// map a link address to its holding register slot
	function automatic logic [1:0] reg_slot(input logic [ADDR_W-1:0] a);
		case (a)
			ADDR_CONTROL: return SLOT_CTRL;
			ADDR_COMPARE: return SLOT_CMP;
			ADDR_COUNTER: return SLOT_CNT;
			default:      return SLOT_NONE;
		endcase
	endfunction

	// low prescaler bits that must all be one for a divided tick
	function automatic logic [DIV_W-1:0] div_mask(input logic [2:0] sel);
		case (sel)
			3'h2:    return 10'h007;
			3'h3:    return 10'h01F;
			3'h4:    return 10'h03F;
			3'h5:    return 10'h07F;
			3'h6:    return 10'h0FF;
			3'h7:    return 10'h3FF;
			default: return 10'h000;
		endcase
	endfunction

endpackage

/* verilog/timer_link_if.sv */
`timescale 1ns/1ns
interface timer_link_if;
	import async_timer_pkg::*;

	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic              wr;
	logic              rd;
	logic [DATA_W-1:0] rdata;
	logic [NREG-1:0]   busy;
	sleep_mode_t       sleep_mode;
	logic              wake;
	logic              irq;

	modport device (
		input  addr, wdata, wr, rd, sleep_mode,
		output rdata, busy, wake, irq
	);

	modport host (
		output addr, wdata, wr, rd, sleep_mode,
		input  rdata, busy, wake, irq
	);
endinterface

/* verilog/timer_prescaler.sv */
`timescale 1ns/1ns
module timer_prescaler
(
	// clock and reset
	input  wire logic       CLK,
	input  wire logic       RESETN,
	// source clock tick and control
	input  wire logic       src_tick,
	input  wire logic       clear,
	input  wire logic [2:0] sel,
	// divided tick
	output logic            tick
);
	import async_timer_pkg::*;

	logic [DIV_W-1:0] div_r;
	logic [DIV_W-1:0] mask;

	initial
	begin
		if (DIV_W < 10)
			$error("prescaler too narrow for the largest division");
	end

	// free-running divider on the source tick, cleared by the reset bit
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			div_r <= '0;
		else if (clear)
			div_r <= '0;
		else if (src_tick)
			div_r <= div_r + 10'h001;
	end

	// select 0 stops, 1 passes, 2..7 divide
	always_comb
	begin
		mask = div_mask(sel);
		tick = src_tick && (sel != 3'h0) && ((div_r & mask) == mask);
	end
endmodule

/* verilog/async_timer_device.sv */
`timescale 1ns/1ns
// Function
// - writes pass holding register, two source clock edges
// - three independent holding registers
// - software waits for busy before rewriting
// - per-register busy flags in status register
// - no compare match while counter/compare pending
// - counter read via edge-refreshed shadow register
// - flags visible three cycles plus timer cycle
// - compare pin changes on timer tick
// - wake starts on next timer cycle
// - interrupt logic rearms after one oscillator cycle
// - ordered clock source switch sequence
// - busy clear before power-save entry
// - write, wait busy, then sleep
// - counter read after busy cycle on wake
// - oscillator runs only with async select, stops in deep sleep
// - wait for oscillator settle before use
// - io clock default, async select detaches pins
// - prescaler divisions and stop setting
// - prescaler reset bit clears prescaler
// - clock select field encoding
module async_timer_device
(
	// clock and reset
	input  wire logic    CLK,
	input  wire logic    RESETN,
	// processor link
	timer_link_if.device LINK,
	// oscillator pin and outputs
	input  wire logic    OSC_IN,
	output logic         OSC_RUN,
	output logic         PORT_DETACH,
	output logic         COMPARE_OUT
);
	import async_timer_pkg::*;

	logic                osc_s1_r;
	logic                osc_s2_r;
	logic                osc_s3_r;
	logic                osc_edge;
	logic                async_sel_r;
	logic                cpu_asleep;
	logic                deep_sleep;
	logic                save_sleep;
	logic                src_tick;
	logic                pre_tick;
	logic [1:0]          wslot;
	logic [DATA_W-1:0]   hold_r [NREG];
	logic [1:0]          edges_r [NREG];
	logic [NREG-1:0]     busy_r;
	logic [NREG-1:0]     xfer_done;
	logic [DATA_W-1:0]   cnt_r;
	logic [DATA_W-1:0]   cmp_r;
	logic [DATA_W-1:0]   ctrl_r;
	logic [DATA_W-1:0]   shadow_r;
	logic                match;
	logic                ovf;
	logic [NFLAG-1:0]    evt;
	logic [NFLAG-1:0]    evt_hold_r;
	logic [NFLAG-1:0]    evt_pipe_r [IRQ_SYNC_CYCLES];
	logic [NFLAG-1:0]    flag_r;
	logic [NFLAG-1:0]    flag_clr;
	logic [NFLAG-1:0]    mask_r;
	logic                psr_r;
	logic                irq_r;
	logic                wake_r;
	logic                wake_pend_r;
	logic                armed_r;
	logic                cmp_out_r;
	logic                osc_run_r;
	logic                detach_r;
	logic [DATA_W-1:0]   rdata_r;

	// oscillator pin through two flops, edge found between second and third
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			osc_s1_r <= 1'b0;
			osc_s2_r <= 1'b0;
			osc_s3_r <= 1'b0;
		end
		else
		begin
			osc_s1_r <= OSC_IN;
			osc_s2_r <= osc_s1_r;
			osc_s3_r <= osc_s2_r;
		end
	end

	assign osc_edge   = osc_s2_r & ~osc_s3_r;
	assign cpu_asleep = LINK.sleep_mode inside {SLP_POWER_SAVE, SLP_EXT_STANDBY,
		SLP_POWER_DOWN, SLP_STANDBY};
	assign deep_sleep = LINK.sleep_mode inside {SLP_POWER_DOWN, SLP_STANDBY};
	assign save_sleep = LINK.sleep_mode inside {SLP_POWER_SAVE, SLP_EXT_STANDBY};
	// io clock by default, oscillator edges once async is selected
	assign src_tick   = async_sel_r ? (osc_edge & ~deep_sleep) : ~cpu_asleep;
	assign wslot      = reg_slot(LINK.addr);

	timer_prescaler u_prescaler (
		.CLK      (CLK),
		.RESETN   (RESETN),
		.src_tick (src_tick),
		.clear    (psr_r),
		.sel      (ctrl_r[CS_MSB:CS_LSB]),
		.tick     (pre_tick)
	);

	// holding registers: load on write, count source edges, then transfer
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			busy_r <= '0;
			for (int i = 0; i < NREG; i++)
			begin
				hold_r[i]  <= BYTE_RESET;
				edges_r[i] <= 2'h0;
			end
		end
		else
		begin
			for (int i = 0; i < NREG; i++)
			begin
				if (LINK.wr && wslot == 2'(i))
				begin
					hold_r[i]  <= LINK.wdata;
					busy_r[i]  <= 1'b1;
					edges_r[i] <= 2'h0;
				end
				else if (xfer_done[i])
					busy_r[i] <= 1'b0;
				else if (busy_r[i] && src_tick)
					edges_r[i] <= edges_r[i] + 2'h1;
			end
		end
	end

	// a transfer completes on the second source edge after the write
	always_comb
	begin
		for (int i = 0; i < NREG; i++)
			xfer_done[i] = busy_r[i] && src_tick && (edges_r[i] == XFER_LAST);
	end

	// destination registers in the timer domain
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			cnt_r  <= BYTE_RESET;
			cmp_r  <= BYTE_RESET;
			ctrl_r <= BYTE_RESET;
		end
		else
		begin
			if (xfer_done[SLOT_CNT])
				cnt_r <= hold_r[SLOT_CNT];
			else if (pre_tick)
				cnt_r <= cnt_r + BYTE_ONE;
			if (xfer_done[SLOT_CMP])
				cmp_r <= hold_r[SLOT_CMP];
			if (xfer_done[SLOT_CTRL])
				ctrl_r <= hold_r[SLOT_CTRL];
		end
	end

	// compare is blocked while counter or compare transfer is pending
	assign match = pre_tick && (cnt_r == cmp_r) && !busy_r[SLOT_CMP] && !busy_r[SLOT_CNT];
	assign ovf   = pre_tick && (cnt_r == BYTE_MAX);
	always_comb
	begin
		evt           = '0;
		evt[FLAG_CMP] = match;
		evt[FLAG_OVF] = ovf;
	end

	// compare pin toggles in the tick cycle itself, no processor resync
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			cmp_out_r <= 1'b0;
		else if (match && ctrl_r[CTRL_TOGGLE_BIT])
			cmp_out_r <= ~cmp_out_r;
	end

	// events wait one timer cycle, then three processor cycles
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			evt_hold_r <= '0;
			for (int i = 0; i < IRQ_SYNC_CYCLES; i++)
				evt_pipe_r[i] <= '0;
		end
		else
		begin
			if (src_tick)
				evt_hold_r <= evt;
			else
				evt_hold_r <= evt_hold_r | evt;
			evt_pipe_r[0] <= src_tick ? evt_hold_r : '0;
			for (int i = 1; i < IRQ_SYNC_CYCLES; i++)
				evt_pipe_r[i] <= evt_pipe_r[i-1];
		end
	end

	// flags: write one clears, a new event wins over the clear
	assign flag_clr = (LINK.wr && LINK.addr == ADDR_FLAGS) ? LINK.wdata[NFLAG-1:0] : '0;
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			flag_r <= '0;
			irq_r  <= 1'b0;
		end
		else
		begin
			flag_r <= (flag_r & ~flag_clr) | evt_pipe_r[IRQ_SYNC_CYCLES-1];
			irq_r  <= |(flag_r & mask_r);
		end
	end

	// wake from power-save on the next timer cycle, rearm one cycle later
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			wake_pend_r <= 1'b0;
			wake_r      <= 1'b0;
			armed_r     <= 1'b1;
		end
		else
		begin
			if (save_sleep && armed_r && !wake_r && |(evt & mask_r))
				wake_pend_r <= 1'b1;
			else if (wake_r)
				wake_pend_r <= 1'b0;
			if (wake_pend_r && src_tick)
				wake_r <= 1'b1;
			else if (LINK.sleep_mode == SLP_AWAKE)
				wake_r <= 1'b0;
			if (wake_r)
				armed_r <= 1'b0;
			else if (src_tick)
				armed_r <= 1'b1;
		end
	end

	// shadow of the counter, frozen while the io clock sleeps
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			shadow_r <= BYTE_RESET;
		else if (!cpu_asleep && (osc_edge || !async_sel_r))
			shadow_r <= cnt_r;
	end

	// control writes: async select, prescaler reset pulse, masks
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			async_sel_r <= 1'b0;
			psr_r       <= 1'b0;
			mask_r      <= '0;
			osc_run_r   <= 1'b0;
			detach_r    <= 1'b0;
		end
		else
		begin
			psr_r <= LINK.wr && LINK.addr == ADDR_SFR && LINK.wdata[PSR_BIT];
			if (LINK.wr && LINK.addr == ADDR_STATUS)
				async_sel_r <= LINK.wdata[ASYNC_SEL_BIT];
			if (LINK.wr && LINK.addr == ADDR_MASK)
				mask_r <= LINK.wdata[NFLAG-1:0];
			osc_run_r <= async_sel_r && !deep_sleep;
			detach_r  <= async_sel_r;
		end
	end

	// read data stands in the cycle after the read strobe
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			rdata_r <= BYTE_RESET;
		else if (!LINK.rd)
			rdata_r <= BYTE_RESET;
		else
		begin
			case (LINK.addr)
				ADDR_COUNTER: rdata_r <= shadow_r;
				ADDR_COMPARE: rdata_r <= cmp_r;
				ADDR_CONTROL: rdata_r <= ctrl_r;
				ADDR_STATUS:  rdata_r <= {4'h0, async_sel_r, busy_r};
				ADDR_MASK:    rdata_r <= {6'h00, mask_r};
				ADDR_FLAGS:   rdata_r <= {6'h00, flag_r};
				default:      rdata_r <= BYTE_RESET;
			endcase
		end
	end

	assign LINK.rdata = rdata_r;
	assign LINK.busy  = busy_r;
	assign LINK.wake  = wake_r;
	assign LINK.irq   = irq_r;
	assign OSC_RUN     = osc_run_r;
	assign PORT_DETACH = detach_r;
	assign COMPARE_OUT = cmp_out_r;
endmodule

/* verilog/async_timer_host.sv */
`timescale 1ns/1ns
module async_timer_host
#(
	parameter int SETTLE_CYCLES = async_timer_pkg::OSC_SETTLE_CYCLES
)
(
	// clock and reset
	input  wire logic                           CLK,
	input  wire logic                           RESETN,
	// software port
	input  wire logic [async_timer_pkg::ADDR_W-1:0] ADDR,
	input  wire logic [async_timer_pkg::DATA_W-1:0] WDATA,
	input  wire logic                           WR,
	input  wire logic                           RD,
	output logic [async_timer_pkg::DATA_W-1:0]  RDATA,
	output logic                                REFUSED,
	// sleep control
	input  wire async_timer_pkg::sleep_mode_t   SLEEP_REQ,
	output async_timer_pkg::sleep_mode_t        SLEEP_STATE,
	output logic                                READY,
	// timer link
	timer_link_if.host                          LINK
);
	import async_timer_pkg::*;

	logic [31:0]       settle_r;
	logic              ready_r;
	logic [1:0]        slot;
	logic              refuse_wr;
	logic              refuse_rd;
	logic              acc_wr;
	logic              refused_r;
	logic [NFLAG-1:0]  mask_mirror_r;
	logic              async_mirror_r;
	logic              switch_pend_r;
	logic [NREG-1:0]   written_r;
	logic [NREG-1:0]   busy_prev_r;
	logic [NREG-1:0]   busy_fell;
	logic              wake_guard_r;
	logic              cnt_ok_r;
	sleep_mode_t       sleep_r;

	initial
	begin
		if (SETTLE_CYCLES < 1)
			$error("settle count must be at least one");
	end

	assign slot      = reg_slot(ADDR);
	assign busy_fell = busy_prev_r & ~LINK.busy;

	// gate software accesses by the timer's safe-use rules
	always_comb
	begin
		refuse_wr = !ready_r || sleep_r != SLP_AWAKE;
		if (slot != SLOT_NONE && LINK.busy[slot])
			refuse_wr = 1'b1;
		if (ADDR == ADDR_STATUS && WDATA[ASYNC_SEL_BIT] != async_mirror_r
			&& mask_mirror_r != '0)
			refuse_wr = 1'b1;
		if (ADDR == ADDR_MASK && WDATA[NFLAG-1:0] != '0 && switch_pend_r)
			refuse_wr = 1'b1;
		refuse_rd = !ready_r || sleep_r != SLP_AWAKE
			|| (ADDR == ADDR_COUNTER && !cnt_ok_r);
	end

	assign acc_wr     = WR && !refuse_wr;
	assign LINK.addr  = ADDR;
	assign LINK.wdata = WDATA;
	assign LINK.wr    = acc_wr;
	assign LINK.rd    = RD && !refuse_rd;

	// mirrors of the switch-related state and the switch sequence tracker
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			mask_mirror_r  <= '0;
			async_mirror_r <= 1'b0;
			switch_pend_r  <= 1'b0;
			written_r      <= '0;
			busy_prev_r    <= '0;
			refused_r      <= 1'b0;
		end
		else
		begin
			busy_prev_r <= LINK.busy;
			refused_r   <= (WR && refuse_wr) || (RD && refuse_rd);
			if (acc_wr && ADDR == ADDR_MASK)
				mask_mirror_r <= WDATA[NFLAG-1:0];
			if (acc_wr && ADDR == ADDR_STATUS && WDATA[ASYNC_SEL_BIT] != async_mirror_r)
			begin
				async_mirror_r <= WDATA[ASYNC_SEL_BIT];
				switch_pend_r  <= 1'b1;
				written_r      <= '0;
			end
			else
			begin
				if (acc_wr && slot != SLOT_NONE)
					written_r[slot] <= 1'b1;
				if (&written_r && LINK.busy == '0)
					switch_pend_r <= 1'b0;
			end
		end
	end

	// sleep entry waits for idle holding registers; save-mode entry after a wake also waits for a holding register transfer to complete
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			sleep_r      <= SLP_AWAKE;
			wake_guard_r <= 1'b0;
			cnt_ok_r     <= 1'b1;
			settle_r     <= 32'(SETTLE_CYCLES - 1);
			ready_r      <= 1'b0;
		end
		else
		begin
			ready_r <= settle_r == 32'h0000_0000;
			if (settle_r != 32'h0000_0000)
				settle_r <= settle_r - 32'h0000_0001;
			if (|busy_fell)
				wake_guard_r <= 1'b0;
			if (busy_fell[SLOT_CMP] || busy_fell[SLOT_CTRL])
				cnt_ok_r <= 1'b1;
			if (sleep_r == SLP_AWAKE)
			begin
				if (SLEEP_REQ != SLP_AWAKE && LINK.busy == '0 && ready_r && !acc_wr
					&& !(wake_guard_r && SLEEP_REQ inside {SLP_POWER_SAVE,
					SLP_EXT_STANDBY}))
					sleep_r <= SLEEP_REQ;
			end
			else if (LINK.wake || SLEEP_REQ == SLP_AWAKE)
			begin
				sleep_r      <= SLP_AWAKE;
				wake_guard_r <= 1'b1;
				if (sleep_r inside {SLP_POWER_SAVE, SLP_EXT_STANDBY})
					cnt_ok_r <= 1'b0;
				if (sleep_r inside {SLP_POWER_DOWN, SLP_STANDBY})
				begin
					settle_r <= 32'(SETTLE_CYCLES - 1);
					ready_r  <= 1'b0;
				end
			end
		end
	end

	assign LINK.sleep_mode = sleep_r;
	assign SLEEP_STATE     = sleep_r;
	assign RDATA           = LINK.rdata;
	assign REFUSED         = refused_r;
	assign READY           = ready_r;
endmodule

/* dv/async_timer_properties.sv */
`timescale 1ns/1ns
module async_timer_properties
(
	// clock and reset
	input wire logic                               CLK,
	input wire logic                               RESETN,
	// host side of the link
	input wire logic [async_timer_pkg::ADDR_W-1:0] addr,
	input wire logic [async_timer_pkg::DATA_W-1:0] wdata,
	input wire logic                               wr,
	input wire logic                               rd,
	input wire async_timer_pkg::sleep_mode_t       sleep_mode,
	// device side of the link
	input wire logic [async_timer_pkg::DATA_W-1:0] rdata,
	input wire logic [async_timer_pkg::NREG-1:0]   busy,
	input wire logic                               wake,
	input wire logic                               irq
);
	import async_timer_pkg::*;

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESETN);

	// forwarded writes to the timer registers
	sequence cnt_write;
		wr && addr == ADDR_COUNTER;
	endsequence
	sequence cmp_write;
		wr && addr == ADDR_COMPARE;
	endsequence
	// busy raised and still up at the second edge
	sequence cmp_busy_pair;
		busy[SLOT_CMP] ##1 busy[SLOT_CMP];
	endsequence

	cnt_busy_set_a: assert property (cnt_write |=> busy[SLOT_CNT])
		else $error("counter busy not raised by write");
	cmp_busy_hold_a: assert property (cmp_write |=> cmp_busy_pair)
		else $error("compare busy dropped before two source edges");
	busy_clear_bound_a: assert property ($rose(busy[SLOT_CTRL]) |->
		##[2:80] !busy[SLOT_CTRL])
		else $error("control busy did not clear in time");
	cnt_busy_cause_a: assert property ($rose(busy[SLOT_CNT]) |->
		$past(wr && addr == ADDR_COUNTER))
		else $error("counter busy raised without counter write");
	status_read_a: assert property (rd && addr == ADDR_STATUS |=>
		rdata[NREG-1:0] == $past(busy))
		else $error("status read does not show busy flags");
	cmp_rewrite_guard_a: assert property (cmp_write |-> !busy[SLOT_CMP])
		else $error("compare rewritten while transfer pending");
	wake_mode_a: assert property ($rose(wake) |->
		$past(sleep_mode) inside {SLP_POWER_SAVE, SLP_EXT_STANDBY})
		else $error("wake outside a save mode");
	// no pending transfer and no write landing in the entry cycle
	sleep_entry_a: assert property ($changed(sleep_mode) && sleep_mode != SLP_AWAKE |->
		$past(busy) == '0 && !$past(wr))
		else $error("sleep entered with transfer pending");
	wake_release_a: assert property (wake && sleep_mode == SLP_AWAKE |-> ##[0:2] !wake)
		else $error("wake not released after return to awake");
endmodule

/* dv/testbench.sv */
`timescale 1ns/1ns
module testbench;
	import async_timer_pkg::*;

	localparam int DIVS [8] = '{1, 1, 8, 32, 64, 128, 256, 1024};

	logic              clk, resetn, osc_in, wr, rd, refused, ready;
	logic              osc_run, port_detach, compare_out, r;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata, q, c0, c1;
	sleep_mode_t       sleep_req, sleep_state;
	int                error_cnt, tests_run, n;

	timer_link_if i_timer_link_if();

	async_timer_host #(.SETTLE_CYCLES(20)) i_async_timer_host (
		.CLK(clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .REFUSED(refused), .SLEEP_REQ(sleep_req),
		.SLEEP_STATE(sleep_state), .READY(ready), .LINK(i_timer_link_if));

	async_timer_device i_async_timer_device (
		.CLK(clk), .RESETN(resetn), .LINK(i_timer_link_if), .OSC_IN(osc_in),
		.OSC_RUN(osc_run), .PORT_DETACH(port_detach), .COMPARE_OUT(compare_out));

	async_timer_properties i_async_timer_properties (
		.CLK(clk), .RESETN(resetn), .addr(i_timer_link_if.addr),
		.wdata(i_timer_link_if.wdata), .wr(i_timer_link_if.wr), .rd(i_timer_link_if.rd),
		.sleep_mode(i_timer_link_if.sleep_mode), .rdata(i_timer_link_if.rdata),
		.busy(i_timer_link_if.busy), .wake(i_timer_link_if.wake), .irq(i_timer_link_if.irq));

	// system clock and free running oscillator pin
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial
	begin
		osc_in = 1'b0;
		forever #23 osc_in = ~osc_in;
	end

	// print counts and verdict, then end the run
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one strobe cycle; read data and refusal land in the following cycle
	task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		output logic [DATA_W-1:0] qo, output logic ro);
		@(posedge clk);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		#1;
		qo = rdata;
		ro = refused;
	endtask

	task automatic wr_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic e);
		logic [DATA_W-1:0] qo;
		logic ro;
		acc(1'b1, a, d, qo, ro);
		check(ro, e);
	endtask

	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		logic [DATA_W-1:0] qo;
		logic ro;
		acc(1'b0, a, BYTE_RESET, qo, ro);
		check(qo, e);
	endtask

	// poll the status register until no transfer is pending
	task automatic wait_idle();
		logic [DATA_W-1:0] qo;
		logic ro;
		int k;
		k = 0;
		qo = BYTE_MAX;
		while (qo[NREG-1:0] !== 3'h0 && k < 100)
		begin
			acc(1'b0, ADDR_STATUS, BYTE_RESET, qo, ro);
			k++;
		end
		check({5'h00, qo[NREG-1:0]}, BYTE_RESET);
	endtask

	// watchdog well beyond the expected run length
	initial
	begin
		repeat (60000) @(posedge clk);
		error_cnt++;
		stop_test();
	end

	// main sequence
	initial
	begin
		error_cnt = 0;
		tests_run = 0;
		resetn = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = '0;
		wdata = '0;
		sleep_req = SLP_AWAKE;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		wr_chk(ADDR_COMPARE, BYTE_ONE, 1'b1);
		n = 0;
		while (ready !== 1'b1 && n < 100)
		begin
			@(posedge clk);
			n++;
		end
		check(ready, 1'b1);
		rd_chk(ADDR_STATUS, BYTE_RESET);
		check(port_detach, 1'b0);
		rd_chk(3'h7, BYTE_RESET);
		// every clock select code, counted over four divided periods
		for (int s = 0; s < 8; s++)
		begin
			wr_chk(ADDR_CONTROL, 8'(s), 1'b0);
			wait_idle();
			wr_chk(ADDR_SFR, BYTE_ONE, 1'b0);
			// open the window after the cycle in which the clear lands
			@(posedge clk);
			acc(1'b0, ADDR_COUNTER, BYTE_RESET, c0, r);
			repeat (DIVS[s] * 4 - 2) @(posedge clk);
			acc(1'b0, ADDR_COUNTER, BYTE_RESET, c1, r);
			check(c1 - c0, (s == 0) ? 8'h00 : 8'h04);
		end
		// switch to the oscillator in the safe order
		wr_chk(ADDR_STATUS, 8'h08, 1'b0);
		wr_chk(ADDR_MASK, 8'h02, 1'b1);
		check(port_detach, 1'b1);
		check(osc_run, 1'b1);
		wr_chk(ADDR_COUNTER, 8'hF0, 1'b0);
		wr_chk(ADDR_COMPARE, 8'hF8, 1'b0);
		wr_chk(ADDR_CONTROL, 8'h11, 1'b0);
		rd_chk(ADDR_STATUS, 8'h0F);
		wr_chk(ADDR_COMPARE, 8'h10, 1'b1);
		wait_idle();
		wr_chk(ADDR_FLAGS, 8'h03, 1'b0);
		wr_chk(ADDR_MASK, 8'h02, 1'b0);
		wr_chk(ADDR_STATUS, BYTE_RESET, 1'b1);
		// compare match reaches the flag and the pin
		n = 0;
		while (i_timer_link_if.irq !== 1'b1 && n < 4000)
		begin
			@(posedge clk);
			n++;
		end
		check(i_timer_link_if.irq, 1'b1);
		check(compare_out, 1'b1);
		acc(1'b0, ADDR_FLAGS, BYTE_RESET, q, r);
		check(q & 8'h02, 8'h02);
		acc(1'b0, ADDR_COUNTER, BYTE_RESET, q, r);
		check({7'h00, q >= 8'hF9}, BYTE_ONE);
		wr_chk(ADDR_FLAGS, 8'h03, 1'b0);
		// power-save, woken by the next compare match
		@(posedge clk);
		sleep_req <= SLP_POWER_SAVE;
		n = 0;
		while (i_timer_link_if.wake !== 1'b1 && n < 5000)
		begin
			@(posedge clk);
			n++;
		end
		check(i_timer_link_if.wake, 1'b1);
		sleep_req <= SLP_AWAKE;
		repeat (3) @(posedge clk);
		acc(1'b0, ADDR_COUNTER, BYTE_RESET, q, r);
		check(r, 1'b1);
		wr_chk(ADDR_CONTROL, 8'h11, 1'b0);
		wait_idle();
		acc(1'b0, ADDR_COUNTER, BYTE_RESET, q, r);
		check(r, 1'b0);
		// deep sleep stops the oscillator and restarts settling
		@(posedge clk);
		sleep_req <= SLP_POWER_DOWN;
		repeat (10) @(posedge clk);
		check(osc_run, 1'b0);
		check(8'(sleep_state), 8'(SLP_POWER_DOWN));
		sleep_req <= SLP_AWAKE;
		repeat (3) @(posedge clk);
		check(ready, 1'b0);
		check(8'(sleep_state), 8'(SLP_AWAKE));
		stop_test();
	end
endmodule
